// ==== bench/eag_gpr_model.sv ====
`timescale 1ns/10ps
// Register file stand-in; a write lands on the clock edge, so a read shows the value at execution.
module eag_gpr_model
  import eag_pkg::*;
(
  input  wire logic        i_mclk,
  input  wire logic        i_we,
  input  wire logic [2:0]  i_sel,
  input  wire logic [31:0] i_data,
  output logic [255:0]     o_gpr_flat
);
  // Register r sits at bits 32r up; there is no reset, so the bench loads all eight.
  always_ff @(posedge i_mclk) begin
    if (i_we) begin
      o_gpr_flat[i_sel*32 +: 32] <= i_data;
    end
  end
endmodule // eag_gpr_model

// ==== bench/test_effective_address_generator.sv ====
`timescale 1ns/10ps
module test_effective_address_generator;
  import eag_pkg::*;
  logic           i_mclk, i_rst, i_req, we, i_protected, i_paging_en, o_valid, o_fault;
  eag_mode_t      i_mode;
  eag_size_t      i_size;
  logic [2:0]     i_base_sel, i_index_sel, wsel;
  logic [1:0]     i_scale_factor;
  logic [31:0]    i_displacement_value, i_seg_base, i_store_data, wdat;
  logic [31:0]    o_offset_address, o_linear_addr, o_phys_addr, o_store_bytes;
  logic [19:0]    i_page_frame;
  logic [255:0]   i_gpr_flat;
  logic [3:0]     o_lane_en;
  int             n_errors = 0;
  int             cmp_count = 0;
  // Use of base, index, scale, displacement for one-hot mode bit k, in nibble k.
  localparam logic [35:0] USE = 36'hF_DEC7_5981;

  eag_offset_unit eag_offset_unit_inst (.i_mclk(i_mclk), .i_rst(i_rst), .i_req(i_req),
    .i_mode(i_mode), .i_base_sel(i_base_sel), .i_index_sel(i_index_sel),
    .i_scale_factor(i_scale_factor), .i_displacement_value(i_displacement_value),
    .i_gpr_flat(i_gpr_flat), .i_protected(i_protected), .i_seg_base(i_seg_base),
    .i_paging_en(i_paging_en), .i_page_frame(i_page_frame), .i_size(i_size),
    .i_store_data(i_store_data), .o_valid(o_valid), .o_fault(o_fault),
    .o_offset_address(o_offset_address), .o_linear_addr(o_linear_addr),
    .o_phys_addr(o_phys_addr), .o_store_bytes(o_store_bytes), .o_lane_en(o_lane_en));
  eag_gpr_model eag_gpr_model_inst (.i_mclk(i_mclk), .i_we(we), .i_sel(wsel), .i_data(wdat),
    .o_gpr_flat(i_gpr_flat));

  // Clock at 20 MHz.
  initial begin
    i_mclk = 1'b0;
    forever #25 i_mclk = ~i_mclk;
  end

  // Register contents chosen so that sums carry past bit 31.
  function automatic logic [31:0] gv(input int r);
    return 32'h8765_4321 + r * 32'h1357_9BDF;
  endfunction

  // Offset from the mode table; the 32-bit return drops any carry.
  function automatic logic [31:0] eo(input int k, input int b, input int x, input int sf,
                                     input logic [31:0] d);
    logic [3:0] u;
    u = USE[k*4 +: 4];
    return (u[3] ? gv(b) : 32'h0) + (u[2] ? gv(x) << (u[1] ? sf : 0) : 32'h0) + (u[0] ? d : 32'h0);
  endfunction

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      n_errors++;
      $display("mismatch %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // One request pulse; the answer is looked at in the single cycle that o_valid stands.
  task automatic issue(input logic [8:0] m, input logic [2:0] b, input logic [2:0] x);
    @(negedge i_mclk);
    i_mode = eag_mode_t'(m);
    i_base_sel = b;
    i_index_sel = x;
    i_req = 1'b1;
    @(negedge i_mclk);
    i_req = 1'b0;
    chk("valid", 32'h1, {31'h0, o_valid});
  endtask

  task automatic t_modes();
    logic [31:0] e;
    i_protected = 1'b1;
    i_displacement_value = 32'hFFFF_FFF0;
    i_seg_base = 32'h1000_0000;
    for (int sf = 0; sf < 4; sf++) begin
      i_scale_factor = 2'(sf);
      for (int k = 0; k < 9; k++) begin
        issue(9'h001 << k, 3'(7 - sf), 3'(sf));
        e = eo(k, 7 - sf, sf, sf, 32'hFFFF_FFF0);
        chk("offset", e, o_offset_address);
        chk("linear", e + 32'h1000_0000, o_linear_addr);
        chk("phys", e + 32'h1000_0000, o_phys_addr);
      end
    end
  endtask

  task automatic t_real();
    logic [31:0] e;
    logic [31:0] l;
    i_protected = 1'b0;
    i_seg_base = 32'hABCD_F123;
    i_scale_factor = 2'h2;
    i_displacement_value = 32'h0000_7FF0;
    issue(9'h100, 3'h6, 3'h1);
    e = eo(8, 6, 1, 2, 32'h0000_7FF0) & 32'h0000_FFFF;
    l = (32'h000F_1230 + e) & 32'h000F_FFFF;
    chk("real offset", e, o_offset_address);
    chk("real linear", l, o_linear_addr);
    chk("real phys", l, o_phys_addr);
  endtask

  task automatic t_page();
    logic [31:0] l;
    i_protected = 1'b1;
    i_paging_en = 1'b1;
    i_seg_base = 32'h0000_2000;
    i_displacement_value = 32'h0000_0FFF;
    issue(9'h004, 3'h3, 3'h0);
    l = gv(3) + 32'h0000_2FFF;
    chk("page linear", l, o_linear_addr);
    chk("page phys", {20'hA_5A5A, l[11:0]}, o_phys_addr);
    i_paging_en = 1'b0;
  endtask

  task automatic t_fault();
    issue(9'h001, 3'h0, 3'h4);
    chk("fault direct", 32'h0, {31'h0, o_fault});
    issue(9'h008, 3'h0, 3'h4);
    chk("fault index", 32'h1, {31'h0, o_fault});
    issue(9'h003, 3'h0, 3'h0);
    chk("fault mode", 32'h1, {31'h0, o_fault});
    @(negedge i_mclk);
    chk("valid drop", 32'h0, {31'h0, o_valid});
    chk("fault hold", 32'h1, {31'h0, o_fault});
  endtask

  task automatic t_lanes();
    logic [3:0] l;
    i_store_data = 32'hC3B2_A190;
    i_displacement_value = 32'h0000_1235;
    for (int s = 0; s < 3; s++) begin
      i_size = eag_size_t'(2'(s));
      l = (s == 0) ? 4'h1 : (s == 1) ? 4'h3 : 4'hF;
      issue(9'h001, 3'h0, 3'h0);
      chk("lanes", {28'h0, l}, {28'h0, o_lane_en});
      chk("bytes", i_store_data & {{8{l[3]}}, {8{l[2]}}, {8{l[1]}}, {8{l[0]}}},
          o_store_bytes);
      chk("low byte addr", 32'h0000_1235, o_offset_address);
    end
  endtask

  task automatic test_done();
    if (n_errors == 0 && cmp_count > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // The tests need some 110 cycles; a hang is cut off well beyond that.
  initial begin
    repeat (3000) @(posedge i_mclk);
    n_errors++;
    test_done();
  end

  // Registers are loaded while reset is held for 20 cycles.
  initial begin
    {i_rst, i_req, we, i_protected, i_paging_en} = 5'h10;
    {i_base_sel, i_index_sel, wsel, i_scale_factor} = 11'h0;
    {i_displacement_value, i_seg_base, i_store_data, wdat} = 128'h0;
    i_mode = EAG_DIRECT;
    i_size = EAG_SZ_DOUBLEWORD_OPERAND;
    i_page_frame = 20'hA_5A5A;
    for (int r = 0; r < 8; r++) begin
      @(negedge i_mclk);
      we = 1'b1;
      wsel = 3'(r);
      wdat = gv(r);
    end
    @(negedge i_mclk);
    we = 1'b0;
    repeat (11) @(negedge i_mclk);
    i_rst = 1'b0;
    t_modes();
    t_real();
    t_page();
    t_fault();
    t_lanes();
    test_done();
  end
endmodule // test_effective_address_generator

// ==== shared/eag_pkg.sv ====
package eag_pkg;

  // Datapath widths.
  localparam int unsigned EAG_AW       = 32;
  localparam int unsigned EAG_RW       = 16;
  localparam int unsigned EAG_REAL_AW  = 20;
  localparam int unsigned EAG_NREG     = 8;
  localparam int unsigned EAG_SELW     = 3;
  localparam int unsigned EAG_PAGE_OFS = 12;

  // Register number of the stack pointer; it may not serve as index.
  localparam logic [2:0] EAG_STACK_PTR_IDX = 3'h4;

  // Reset values.
  localparam logic [31:0] EAG_ADDR_RST = 32'h0000_0000;

  // Addressing combinations, one-hot.
  typedef enum logic [8:0] {
    EAG_DIRECT    = 9'h001,
    EAG_REG_IND   = 9'h002,
    EAG_BASED     = 9'h004,
    EAG_INDEX     = 9'h008,
    EAG_SC_INDEX  = 9'h010,
    EAG_BASE_IDX  = 9'h020,
    EAG_BASE_SIDX = 9'h040,
    EAG_BIDX_DISP = 9'h080,
    EAG_BSIDX_DSP = 9'h100
  } eag_mode_t;

  // Operand size codes.
  typedef enum logic [1:0] {
    EAG_SZ_BYTE = 2'h0,
    EAG_SZ_WORD = 2'h1,
    EAG_SZ_DOUBLEWORD_OPERAND = 2'h2
  } eag_size_t;

endpackage

// ==== verilog/eag_byte_lanes.sv ====
`timescale 1ns/10ps
module eag_byte_lanes
  import eag_pkg::*;
(
  input  wire eag_size_t   i_size,
  input  wire logic [31:0] i_data,
  output logic [31:0]      o_bytes,
  output logic [3:0]       o_lane_en
);

  // Little-endian layout: byte k of the operand goes to address base plus k.
  logic [3:0] lane_mask;

  assign lane_mask = (i_size == EAG_SZ_DOUBLEWORD_OPERAND) ? 4'hF :
                     (i_size == EAG_SZ_WORD)  ? 4'h3 : 4'h1;

  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_lane
      assign o_bytes[8*g +: 8] = lane_mask[g] ? i_data[8*g +: 8] : 8'h00;
      assign o_lane_en[g]      = lane_mask[g];
    end
  endgenerate

endmodule // eag_byte_lanes

// ==== verilog/eag_mode_decode.sv ====
`timescale 1ns/10ps
module eag_mode_decode
  import eag_pkg::*;
(
  input  wire eag_mode_t  i_mode,
  output logic            o_use_base,
  output logic            o_use_index,
  output logic            o_use_scale,
  output logic            o_use_disp,
  output logic            o_valid
);

  // Component presence per addressing combination.
  always_comb begin
    o_use_base  = 1'b0;
    o_use_index = 1'b0;
    o_use_scale = 1'b0;
    o_use_disp  = 1'b0;
    o_valid     = 1'b1;
    // A code that is not one of the nine one-hot combinations is flagged, not guessed at.
    case (i_mode)
      EAG_DIRECT: begin
        o_use_disp = 1'b1;
      end
      EAG_REG_IND: begin
        o_use_base = 1'b1;
      end
      EAG_BASED: begin
        o_use_base = 1'b1;
        o_use_disp = 1'b1;
      end
      EAG_INDEX: begin
        o_use_index = 1'b1;
        o_use_disp  = 1'b1;
      end
      EAG_SC_INDEX: begin
        o_use_index = 1'b1;
        o_use_scale = 1'b1;
        o_use_disp  = 1'b1;
      end
      EAG_BASE_IDX: begin
        o_use_base  = 1'b1;
        o_use_index = 1'b1;
      end
      EAG_BASE_SIDX: begin
        o_use_base  = 1'b1;
        o_use_index = 1'b1;
        o_use_scale = 1'b1;
      end
      EAG_BIDX_DISP: begin
        o_use_base  = 1'b1;
        o_use_index = 1'b1;
        o_use_disp  = 1'b1;
      end
      EAG_BSIDX_DSP: begin
        o_use_base  = 1'b1;
        o_use_index = 1'b1;
        o_use_scale = 1'b1;
        o_use_disp  = 1'b1;
      end
      default: begin
        o_valid = 1'b0;
      end
    endcase
  end

endmodule // eag_mode_decode

// ==== verilog/eag_offset_unit.sv ====
`timescale 1ns/10ps
module eag_offset_unit
  import eag_pkg::*;
(
  input  wire logic                 i_mclk,
  input  wire logic                 i_rst,
  input  wire logic                 i_req,
  input  wire eag_mode_t            i_mode,
  input  wire logic [EAG_SELW-1:0]  i_base_sel,
  input  wire logic [EAG_SELW-1:0]  i_index_sel,
  input  wire logic [1:0]           i_scale_factor,
  input  wire logic [31:0]          i_displacement_value,
  input  wire logic [255:0]         i_gpr_flat,
  input  wire logic                 i_protected,
  input  wire logic [31:0]          i_seg_base,
  input  wire logic                 i_paging_en,
  input  wire logic [19:0]          i_page_frame,
  input  wire eag_size_t            i_size,
  input  wire logic [31:0]          i_store_data,
  output logic                      o_valid,
  output logic                      o_fault,
  output logic [31:0]               o_offset_address,
  output logic [31:0]               o_linear_addr,
  output logic [31:0]               o_phys_addr,
  output logic [31:0]               o_store_bytes,
  output logic [3:0]                o_lane_en
);

  // Per-register view of the flattened register file input.
  logic [31:0] gpr [EAG_NREG];
  genvar r;
  generate
    for (r = 0; r < EAG_NREG; r++) begin : g_gpr
      assign gpr[r] = i_gpr_flat[32*r +: 32];
    end
  endgenerate

  // Addressing combination decode.
  logic use_base;
  logic use_index;
  logic use_scale;
  logic use_disp;
  logic mode_ok;

  eag_mode_decode u_dec (
    .i_mode      (i_mode),
    .o_use_base  (use_base),
    .o_use_index (use_index),
    .o_use_scale (use_scale),
    .o_use_disp  (use_disp),
    .o_valid     (mode_ok)
  );

  // Component selection; missing parts contribute zero.
  wire        index_bad  = use_index && (i_index_sel == EAG_STACK_PTR_IDX);
  wire [31:0] base_val   = use_base ? gpr[i_base_sel] : 32'h0000_0000;
  wire [31:0] index_raw  = use_index ? gpr[i_index_sel] : 32'h0000_0000;
  wire [1:0]  shift_amt  = use_scale ? i_scale_factor : 2'h0;
  wire [31:0] index_val  = index_raw << shift_amt;
  wire [31:0] disp_val   = use_disp ? i_displacement_value : 32'h0000_0000;
  // The 32-bit sum wraps on purpose; the carry out of bit 31 is dropped.
  wire [31:0] sum_full   = base_val + index_val + disp_val;
  wire [31:0] offset_nxt = i_protected ? sum_full :
                           {16'h0000, sum_full[EAG_RW-1:0]};
  wire        fault_nxt  = index_bad || !mode_ok;

  // Segmentation: real mode forms base times sixteen plus offset within 1 MB.
  wire [31:0] real_lin   = {12'h000, 4'h0, i_seg_base[15:0]} << 4;
  wire [31:0] real_sum   = real_lin + offset_nxt;
  wire [31:0] linear_nxt = i_protected ? (i_seg_base + offset_nxt) :
                           {12'h000, real_sum[EAG_REAL_AW-1:0]};
  wire [31:0] phys_nxt   = i_paging_en ?
                           {i_page_frame, linear_nxt[EAG_PAGE_OFS-1:0]} :
                           linear_nxt;

  // Byte lane placement of the operand at the low-byte address.
  logic [31:0] bytes_nxt;
  logic [3:0]  lanes_nxt;

  eag_byte_lanes u_lanes (
    .i_size    (i_size),
    .i_data    (i_store_data),
    .o_bytes   (bytes_nxt),
    .o_lane_en (lanes_nxt)
  );

  // One-cycle result register; outputs other than o_valid hold until the next request.
  always_ff @(posedge i_mclk) begin
    if (i_rst) begin
      o_valid          <= 1'b0;
      o_fault          <= 1'b0;
      o_offset_address <= EAG_ADDR_RST;
      o_linear_addr    <= EAG_ADDR_RST;
      o_phys_addr      <= EAG_ADDR_RST;
      o_store_bytes    <= EAG_ADDR_RST;
      o_lane_en        <= 4'h0;
    end else begin
      o_valid <= i_req;
      if (i_req) begin
        o_fault          <= fault_nxt;
        o_offset_address <= offset_nxt;
        o_linear_addr    <= linear_nxt;
        o_phys_addr      <= phys_nxt;
        o_store_bytes    <= bytes_nxt;
        o_lane_en        <= lanes_nxt;
      end
    end
  end

  // Checks on the registered results.
  default clocking cb @(posedge i_mclk); endclocking
  default disable iff (i_rst);

  valid_follows_req_a: assert property (i_req |=> o_valid)
    else $error("valid did not follow request");
  real_offset_16b_a: assert property (i_req && !i_protected |=> o_offset_address[31:16] == 16'h0000)
    else $error("real mode offset exceeds 16 bits");
  real_linear_1mb_a: assert property (i_req && !i_protected |=> o_linear_addr[31:20] == 12'h000)
    else $error("real mode linear beyond 1 MB");
  prot_offset_full_a: assert property (i_req && i_protected && i_mode == EAG_BSIDX_DSP
    |=> o_offset_address == $past(gpr[i_base_sel] + (gpr[i_index_sel] << i_scale_factor)
                                  + i_displacement_value))
    else $error("protected offset wrong");
  prot_linear_a: assert property (i_req && i_protected
    |=> o_linear_addr == $past(i_seg_base) + o_offset_address)
    else $error("protected linear address wrong");
  flat_phys_a: assert property (i_req && !i_paging_en |=> o_phys_addr == o_linear_addr)
    else $error("unpaged physical address wrong");
  word_lane_a: assert property (i_req && i_size == EAG_SZ_WORD
    |=> o_lane_en == 4'h3 && o_store_bytes[31:16] == 16'h0000)
    else $error("word operand lanes wrong");
  // Reset must silence the result strobe even though other checks are disabled then.
  reset_quiet_a: assert property (disable iff (1'b0) i_rst |=> !o_valid)
    else $error("valid seen after reset");
  stack_idx_fault_a: assert property (i_req && use_index && i_index_sel == 3'h4 |=> o_fault)
    else $error("stack pointer index not faulted");
  direct_disp_a: assert property (i_req && i_protected && i_mode == EAG_DIRECT
                                  |=> o_offset_address == $past(i_displacement_value))
    else $error("direct mode offset wrong");
  page_offset_keep_a: assert property (i_req && i_paging_en |=> o_phys_addr[11:0] == o_linear_addr[11:0])
    else $error("page offset altered");
  byte_lane_a: assert property (i_req && i_size == EAG_SZ_BYTE |=> o_lane_en == 4'h1)
    else $error("byte operand lanes wrong");
  scale_eight_a: assert property (i_req && i_protected && i_mode == EAG_SC_INDEX && i_scale_factor == 2'h3
    |=> o_offset_address == $past(gpr[i_index_sel] * 8 + i_displacement_value))
    else $error("scale of eight wrong");
  base_only_a: assert property (i_req && i_protected && i_mode == EAG_REG_IND
                                |=> o_offset_address == $past(gpr[i_base_sel]))
    else $error("register indirect offset wrong");

  cov_real_c:   cover property (i_req && !i_protected);
  cov_paging_c: cover property (i_req && i_protected && i_paging_en);
  cov_full_c:   cover property (i_req && i_mode == EAG_BSIDX_DSP && i_scale_factor == 2'h3);
  cov_fault_c:  cover property (i_req && index_bad);
  cov_word_c:   cover property (i_req && i_size == EAG_SZ_WORD);

endmodule // eag_offset_unit
